// ===== psf_pkg.sv
// constants and types for the precise sample and off-core filter block
package psf_pkg;
  localparam logic [31:0] MSR_FILTER0_ADDR = 32'h0000_01A6;
  localparam logic [31:0] MSR_FILTER1_ADDR = 32'h0000_01A7;
  localparam logic [63:0] FILTER_RESET = 64'h0000_0000_0000_0000;
  localparam int REQ_LSB = 0;
  localparam int REQ_MSB = 15;
  localparam int SUPP_LSB = 16;
  localparam int SUPP_MSB = 30;
  localparam int SNOOP_LSB = 31;
  localparam int SNOOP_MSB = 37;
  localparam int REQ_DEMAND_READ = 0;
  localparam int REQ_DEMAND_OWN = 1;
  localparam int REQ_MOD_WB = 3;
  localparam int REQ_MID_PF_READ = 7;
  localparam int REQ_MID_PF_OWN = 8;
  localparam int REQ_L1_PF = 10;
  localparam int REQ_STREAM_ST = 11;
  localparam int REQ_CLEAN_WB = 12;
  localparam int REQ_OTHER = 15;
  localparam int SUPP_ANY = 16;
  localparam int SUPP_UNKNOWN = 17;
  localparam int SUPP_L3_MOD = 18;
  localparam int SUPP_L3_EXCL = 19;
  localparam int SUPP_L3_SHARED = 20;
  localparam int SUPP_FOURTH_LEVEL_HIT_MATCH = 22;
  localparam int SUPP_LOCAL_DRAM = 26;
  localparam int SUPP_L4_SUPERLINE = 27;
  localparam logic [7:0] REC_OFS_COUNTER = 8'h90;
  localparam logic [7:0] REC_OFS_ADDR = 8'h98;
  localparam logic [7:0] REC_OFS_STATUS = 8'hA0;
  localparam logic [7:0] REC_OFS_ZERO = 8'hA8;
  localparam int STATUS_HIT_BIT = 0;
  localparam logic [7:0] EVT_INST = 8'hC0;
  localparam logic [7:0] EVT_ASSIST = 8'hC1;
  localparam logic [7:0] EVT_BRANCH = 8'hC4;
  localparam logic [7:0] EVT_MISP = 8'hC5;
  localparam logic [7:0] EVT_HLE = 8'hC8;
  localparam logic [7:0] EVT_RTM = 8'hC9;
  localparam logic [7:0] EVT_MEM_INST = 8'hD0;
  localparam logic [7:0] EVT_LOAD_SRC = 8'hD1;
  localparam logic [7:0] EVT_LOAD_SNOOP = 8'hD2;
  localparam logic [7:0] EVT_UOPS_RETIRED = 8'hC2;
  localparam logic [7:0] UM_UOPS_ALL = 8'h01;
  localparam logic [7:0] UM_STLB_STORE = 8'h12;
  localparam logic [7:0] UM_SPLIT_STORE = 8'h42;
  localparam logic [7:0] UM_ALL_STORES = 8'h82;
  localparam int LOAD_UOPS = 4;
  typedef logic [63:0] psf_word_t;
endpackage

// ===== psf_rec_if.sv
// carrier between the filter core and the sample record writer
`timescale 1ns/10ps
interface psf_rec_if;
  logic start;
  logic profile_en;
  logic [1:0] counter_idx;
  logic [63:0] lin_addr;
  logic store_hit;
  logic hit_valid;
  logic busy;
  modport core (output start, output profile_en, output counter_idx, output lin_addr, output store_hit,
    output hit_valid, input busy);
  modport writer (input start, input profile_en, input counter_idx, input lin_addr, input store_hit,
    input hit_valid, output busy);
endinterface

// ===== psf_rec_writer.sv
// writes sample record entry 90H, then with profiling enabled entries 98H to A8H, one per cycle
`timescale 1ns/10ps
module psf_rec_writer
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  psf_rec_if.writer rec,
  output logic rec_valid,
  output logic [7:0] rec_offset,
  output psf_pkg::psf_word_t rec_data
);
  typedef enum logic [2:0] {PSF_IDLE, PSF_W_CNT, PSF_W_ADDR, PSF_W_STAT, PSF_W_ZERO} psf_wstate_t;
  psf_wstate_t state_r, state_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [63:0] addr_r, addr_nxt;
  logic hit_r, hit_nxt;
  logic prof_r, prof_nxt;
  logic valid_nxt;
  logic [7:0] ofs_nxt;
  psf_word_t data_nxt;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    addr_nxt = addr_r;
    hit_nxt = hit_r;
    prof_nxt = prof_r;
    valid_nxt = 1'b0;
    ofs_nxt = rec_offset;
    data_nxt = rec_data;
    case (state_r)
      PSF_IDLE: begin
        if (rec.start) begin
          idx_nxt = rec.counter_idx;
          addr_nxt = rec.lin_addr;
          hit_nxt = rec.store_hit & rec.hit_valid;
          prof_nxt = rec.profile_en;
          state_nxt = PSF_W_CNT;
        end
      end
      PSF_W_CNT: begin
        valid_nxt = 1'b1;
        ofs_nxt = REC_OFS_COUNTER;
        data_nxt = {62'h0, idx_r};
        state_nxt = prof_r ? PSF_W_ADDR : PSF_IDLE;
      end
      PSF_W_ADDR: begin
        valid_nxt = 1'b1;
        ofs_nxt = REC_OFS_ADDR;
        data_nxt = addr_r;
        state_nxt = PSF_W_STAT;
      end
      PSF_W_STAT: begin
        valid_nxt = 1'b1;
        ofs_nxt = REC_OFS_STATUS;
        data_nxt = 64'h0000_0000_0000_0000;
        data_nxt[STATUS_HIT_BIT] = hit_r;
        state_nxt = PSF_W_ZERO;
      end
      PSF_W_ZERO: begin
        valid_nxt = 1'b1;
        ofs_nxt = REC_OFS_ZERO;
        data_nxt = 64'h0000_0000_0000_0000;
        state_nxt = PSF_IDLE;
      end
      default: begin
        state_nxt = PSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= PSF_IDLE;
      idx_r <= 2'h0;
      addr_r <= 64'h0000_0000_0000_0000;
      hit_r <= 1'b0;
      prof_r <= 1'b0;
      rec_valid <= 1'b0;
      rec_offset <= 8'h00;
      rec_data <= 64'h0000_0000_0000_0000;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      addr_r <= addr_nxt;
      hit_r <= hit_nxt;
      prof_r <= prof_nxt;
      rec_valid <= valid_nxt;
      rec_offset <= ofs_nxt;
      rec_data <= data_nxt;
    end
  end

  assign rec.busy = (state_r != PSF_IDLE);
endmodule

// ===== psf_filter.sv
// precise sample qualifier, off-core response filter registers and matcher
`timescale 1ns/10ps
module psf_filter
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic msr_wr_en,
  input wire logic msr_rd_en,
  input wire logic [31:0] msr_addr,
  input wire psf_pkg::psf_word_t msr_wdata,
  output psf_pkg::psf_word_t msr_rdata,
  output logic msr_rd_valid,
  output logic msr_addr_err,
  input wire logic data_address_profiling_en,
  input wire logic smp_valid,
  input wire logic [7:0] smp_event_select,
  input wire logic [7:0] smp_umask,
  input wire logic [1:0] smp_counter_idx,
  input wire logic [63:0] smp_lin_addr,
  input wire logic smp_first_level_store_hit,
  input wire logic [psf_pkg::LOAD_UOPS-1:0] smp_load_uop_cond,
  output logic precise_event_sampling_count,
  output logic precise_event_sampling_refused,
  input wire logic ocr_valid,
  input wire logic ocr_cfg_sel,
  input wire logic [15:0] ocr_req_type,
  input wire logic [14:0] ocr_supplier,
  output logic ocr_match,
  output logic rec_valid,
  output logic [7:0] rec_offset,
  output psf_pkg::psf_word_t rec_data
);
  import psf_pkg::*;

  psf_rec_if rec ();

  // table of pairs that may use precise sampling
  function automatic logic precise_pair_ok(input logic [7:0] es, input logic [7:0] um);
    logic ok;
    ok = 1'b0;
    case (es)
      EVT_INST: ok = (um == 8'h01);
      EVT_ASSIST: ok = (um == 8'h01);
      EVT_BRANCH: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) || (um == 8'h08) ||
        (um == 8'h20) || (um == 8'h40);
      EVT_MISP: ok = (um == 8'h01) || (um == 8'h04) || (um == 8'h20);
      EVT_HLE: ok = (um == 8'h04);
      EVT_RTM: ok = (um == 8'h04);
      EVT_MEM_INST: ok = (um == 8'h11) || (um == 8'h12) || (um == 8'h21) || (um == 8'h41) ||
        (um == 8'h42) || (um == 8'h81) || (um == 8'h82);
      EVT_LOAD_SRC: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) || (um == 8'h08) ||
        (um == 8'h10) || (um == 8'h20) || (um == 8'h40);
      EVT_LOAD_SNOOP: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04) || (um == 8'h08);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // events whose count depends on load micro-op conditions
  function automatic logic load_qualified(input logic [7:0] es);
    return (es == EVT_MEM_INST) || (es == EVT_LOAD_SRC) || (es == EVT_LOAD_SNOOP);
  endfunction

  // store events for which the first-level hit bit means something
  function automatic logic store_hit_valid(input logic [7:0] es, input logic [7:0] um);
    return ((es == EVT_UOPS_RETIRED) && (um == UM_UOPS_ALL)) ||
      ((es == EVT_MEM_INST) && ((um == UM_STLB_STORE) || (um == UM_SPLIT_STORE) || (um == UM_ALL_STORES)));
  endfunction

  // bits that hold storage; reserved positions read back zero
  function automatic psf_word_t writable_mask();
    psf_word_t m;
    m = 64'h0000_0000_0000_0000;
    m[REQ_DEMAND_READ] = 1'b1;
    m[REQ_DEMAND_OWN] = 1'b1;
    m[REQ_MOD_WB] = 1'b1;
    m[REQ_CLEAN_WB] = 1'b1;
    m[REQ_MID_PF_READ] = 1'b1;
    m[REQ_MID_PF_OWN] = 1'b1;
    m[REQ_L1_PF] = 1'b1;
    m[REQ_STREAM_ST] = 1'b1;
    m[REQ_OTHER] = 1'b1;
    m[SUPP_ANY] = 1'b1;
    m[SUPP_UNKNOWN] = 1'b1;
    m[SUPP_L3_MOD] = 1'b1;
    m[SUPP_L3_EXCL] = 1'b1;
    m[SUPP_L3_SHARED] = 1'b1;
    m[SUPP_FOURTH_LEVEL_HIT_MATCH] = 1'b1;
    m[SUPP_LOCAL_DRAM] = 1'b1;
    m[SUPP_L4_SUPERLINE] = 1'b1;
    m[SNOOP_MSB:SNOOP_LSB] = 7'h7F;
    return m;
  endfunction

  // filter configuration registers and register port
  psf_word_t cfg0_r, cfg0_nxt;
  psf_word_t cfg1_r, cfg1_nxt;
  psf_word_t rdata_nxt;
  logic rd_valid_nxt;
  logic addr_err_nxt;
  logic hit0;
  logic hit1;

  always_comb begin
    hit0 = (msr_addr == MSR_FILTER0_ADDR);
    hit1 = (msr_addr == MSR_FILTER1_ADDR);
    cfg0_nxt = cfg0_r;
    cfg1_nxt = cfg1_r;
    rdata_nxt = msr_rdata;
    rd_valid_nxt = 1'b0;
    addr_err_nxt = 1'b0;
    if (msr_wr_en) begin
      if (hit0) begin
        cfg0_nxt = msr_wdata & writable_mask();
      end else if (hit1) begin
        cfg1_nxt = msr_wdata & writable_mask();
      end else begin
        addr_err_nxt = 1'b1;
      end
    end else if (msr_rd_en) begin
      rd_valid_nxt = 1'b1;
      if (hit0) begin
        rdata_nxt = cfg0_r;
      end else if (hit1) begin
        rdata_nxt = cfg1_r;
      end else begin
        rdata_nxt = 64'h0000_0000_0000_0000;
        addr_err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg0_r <= FILTER_RESET;
      cfg1_r <= FILTER_RESET;
      msr_rdata <= 64'h0000_0000_0000_0000;
      msr_rd_valid <= 1'b0;
      msr_addr_err <= 1'b0;
    end else begin
      cfg0_r <= cfg0_nxt;
      cfg1_r <= cfg1_nxt;
      msr_rdata <= rdata_nxt;
      msr_rd_valid <= rd_valid_nxt;
      msr_addr_err <= addr_err_nxt;
    end
  end

  // off-core response matcher
  psf_word_t cfg_sel;
  logic req_hit;
  logic supp_hit;
  logic match_nxt;

  always_comb begin
    cfg_sel = ocr_cfg_sel ? cfg1_r : cfg0_r;
    req_hit = |(cfg_sel[REQ_MSB:REQ_LSB] & ocr_req_type);
    supp_hit = cfg_sel[SUPP_ANY] | (|(cfg_sel[SUPP_MSB:SUPP_LSB] & ocr_supplier));
    match_nxt = ocr_valid & req_hit & supp_hit;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ocr_match <= 1'b0;
    end else begin
      ocr_match <= match_nxt;
    end
  end

  // precise sample qualification and record launch
  logic pair_ok;
  logic cond_ok;
  logic count_nxt;
  logic refused_nxt;
  logic start_nxt;
  logic start_r;
  logic prof_r;
  logic [1:0] idx_r;
  logic [63:0] addr_r;
  logic hit_r;
  logic hit_valid_r;

  always_comb begin
    pair_ok = precise_pair_ok(smp_event_select, smp_umask);
    cond_ok = !load_qualified(smp_event_select) || (|smp_load_uop_cond);
    count_nxt = smp_valid & pair_ok & cond_ok;
    start_nxt = count_nxt & !rec.busy & !start_r;
    refused_nxt = smp_valid & !(pair_ok & cond_ok & !rec.busy & !start_r);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      precise_event_sampling_count <= 1'b0;
      precise_event_sampling_refused <= 1'b0;
      start_r <= 1'b0;
      prof_r <= 1'b0;
      idx_r <= 2'h0;
      addr_r <= 64'h0000_0000_0000_0000;
      hit_r <= 1'b0;
      hit_valid_r <= 1'b0;
    end else begin
      precise_event_sampling_count <= count_nxt;
      precise_event_sampling_refused <= refused_nxt;
      start_r <= start_nxt;
      if (start_nxt) begin
        prof_r <= data_address_profiling_en;
        idx_r <= smp_counter_idx;
        addr_r <= smp_lin_addr;
        hit_r <= smp_first_level_store_hit;
        hit_valid_r <= store_hit_valid(smp_event_select, smp_umask);
      end
    end
  end

  assign rec.start = start_r;
  assign rec.profile_en = prof_r;
  assign rec.counter_idx = idx_r;
  assign rec.lin_addr = addr_r;
  assign rec.store_hit = hit_r;
  assign rec.hit_valid = hit_valid_r;

  psf_rec_writer u_writer (
    .sys_clk(sys_clk),
    .rst(rst),
    .rec(rec),
    .rec_valid(rec_valid),
    .rec_offset(rec_offset),
    .rec_data(rec_data)
  );
endmodule

// ===== psf_chk.sv
// assertions on the filter block ports
`timescale 1ns/10ps
module psf_chk
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic msr_wr_en,
  input wire logic msr_rd_en,
  input wire logic [31:0] msr_addr,
  input wire psf_pkg::psf_word_t msr_rdata,
  input wire logic msr_rd_valid,
  input wire logic msr_addr_err,
  input wire logic smp_valid,
  input wire logic [7:0] smp_event_select,
  input wire logic [7:0] smp_umask,
  input wire logic [psf_pkg::LOAD_UOPS-1:0] smp_load_uop_cond,
  input wire logic precise_event_sampling_count,
  input wire logic precise_event_sampling_refused,
  input wire logic ocr_valid,
  input wire logic [15:0] ocr_req_type,
  input wire logic ocr_match,
  input wire logic rec_valid,
  input wire logic [7:0] rec_offset,
  input wire psf_pkg::psf_word_t rec_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic map;
  assign map = msr_addr == MSR_FILTER0_ADDR || msr_addr == MSR_FILTER1_ADDR;
  property p_rd;
    msr_rd_en && !msr_wr_en && map |=> msr_rd_valid && !msr_addr_err;
  endproperty
  a_rd: assert property (p_rd) else $error("mapped read not answered");
  property p_err;
    (msr_rd_en || msr_wr_en) && !map |=> msr_addr_err;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_rsv;
    msr_rd_valid |-> (msr_rdata & ~64'h0000_003F_8C5F_9D8B) == 64'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved config bit read nonzero");
  property p_cnt;
    precise_event_sampling_count |-> $past(smp_valid);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count without sample");
  property p_bad;
    smp_valid && smp_event_select == EVT_LOAD_SRC && smp_umask == 8'h80
      |=> precise_event_sampling_refused && !precise_event_sampling_count;
  endproperty
  a_bad: assert property (p_bad) else $error("unlisted pair counted");
  property p_ld;
    smp_valid && smp_event_select == EVT_LOAD_SRC && smp_load_uop_cond == 4'h0 |=> !precise_event_sampling_count;
  endproperty
  a_ld: assert property (p_ld) else $error("load counted with no uop condition");
  property p_ocr;
    ocr_match |-> $past(ocr_valid && ocr_req_type != 16'h0000);
  endproperty
  a_ocr: assert property (p_ocr) else $error("match without request");
  property p_a8;
    rec_valid && rec_offset == REC_OFS_ZERO |-> rec_data == 64'h0;
  endproperty
  a_a8: assert property (p_a8) else $error("entry a8 nonzero");
  property p_st;
    rec_valid && rec_offset == REC_OFS_STATUS |-> rec_data[63:1] == 63'h0;
  endproperty
  a_st: assert property (p_st) else $error("store status upper bits set");
  property p_seq;
    rec_valid && rec_offset == REC_OFS_ADDR
      |=> rec_valid && rec_offset == REC_OFS_STATUS ##1 rec_valid && rec_offset == REC_OFS_ZERO;
  endproperty
  a_seq: assert property (p_seq) else $error("profiling entries out of order");
endmodule
bind psf_filter psf_chk psf_chk_i (.sys_clk, .rst, .msr_wr_en, .msr_rd_en, .msr_addr, .msr_rdata, .msr_rd_valid,
  .msr_addr_err, .smp_valid, .smp_event_select, .smp_umask, .smp_load_uop_cond, .precise_event_sampling_count,
  .precise_event_sampling_refused, .ocr_valid, .ocr_req_type, .ocr_match, .rec_valid, .rec_offset, .rec_data);

// ===== psf_evt_src.sv
// event source model presenting one sample candidate per request
`timescale 1ns/10ps
module psf_evt_src
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [23:0] fld,
  input wire logic [63:0] addr,
  output logic smp_valid,
  output logic [7:0] smp_event_select,
  output logic [7:0] smp_umask,
  output logic [1:0] smp_counter_idx,
  output logic [63:0] smp_lin_addr,
  output logic smp_first_level_store_hit,
  output logic [psf_pkg::LOAD_UOPS-1:0] smp_load_uop_cond
);
  // event select, umask and address of a finished candidate invert on each cycle without fire, so stale values come back every second cycle
  initial {smp_valid, smp_event_select, smp_umask, smp_counter_idx, smp_lin_addr, smp_first_level_store_hit,
    smp_load_uop_cond} = 88'h0;
  always @(negedge sys_clk) begin
    smp_valid <= fire;
    if (fire) begin
      {smp_event_select, smp_umask, smp_load_uop_cond, smp_counter_idx, smp_first_level_store_hit} <= fld[22:0];
      smp_lin_addr <= addr;
    end else begin
      {smp_event_select, smp_umask, smp_lin_addr} <= ~{smp_event_select, smp_umask, smp_lin_addr};
    end
  end
endmodule

// ===== tb_psf_filter.sv
// testbench for the precise sample and off-core filter block
`timescale 1ns/10ps
module tb_psf_filter;
  import psf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic msr_wr_en = 1'b0;
  logic msr_rd_en = 1'b0;
  logic [31:0] msr_addr = 32'h0;
  psf_word_t msr_wdata = 64'h0;
  psf_word_t msr_rdata, rec_data;
  logic msr_rd_valid, msr_addr_err, cnt, refd, ocr_match, rec_valid;
  logic prof = 1'b0;
  logic fire = 1'b0;
  logic [23:0] fld = 24'h0;
  logic [63:0] addr = 64'h0000_7FFF_1234_5678;
  logic ocr_valid = 1'b0;
  logic ocr_cfg_sel = 1'b0;
  logic [15:0] ocr_req_type = 16'h0;
  logic [14:0] ocr_supplier = 15'h0;
  logic smp_valid, smp_first_level_store_hit;
  logic [7:0] smp_event_select, smp_umask, rec_offset;
  logic [1:0] smp_counter_idx;
  logic [63:0] smp_lin_addr;
  logic [3:0] smp_load_uop_cond;
  logic [1:0] idx = 2'h0;
  logic hit = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_ok = 0;
  logic [71:0] rq[$];
  logic [19:0] tab[] = '{20'h1_C001, 20'h1_C101, 20'h1_C401, 20'h1_C402, 20'h1_C404, 20'h1_C408, 20'h1_C420,
    20'h1_C440, 20'h1_C501, 20'h1_C504, 20'h1_C520, 20'h1_C804, 20'h1_C904, 20'h1_D011, 20'h1_D012, 20'h1_D021,
    20'h1_D041, 20'h1_D042, 20'h1_D081, 20'h1_D082, 20'h1_D101, 20'h1_D102, 20'h1_D104, 20'h1_D108, 20'h1_D110,
    20'h1_D120, 20'h1_D140, 20'h1_D201, 20'h1_D202, 20'h1_D204, 20'h1_D208, 20'h0_C410, 20'h0_C502, 20'h0_C002,
    20'h0_D001, 20'h0_D180, 20'h0_D210, 20'h0_0000};
  logic [17:0] st[] = '{18'h3_D082, 18'h3_D042, 18'h3_D012, 18'h2_C404, 18'h0_D082};
  int rb[] = '{0, 1, 3, 7, 8, 10, 11, 12, 15};
  int sb[] = '{17, 18, 19, 20, 22, 26, 27};
  always #4 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (rec_valid === 1'b1) rq.push_back({rec_offset, rec_data});
  psf_filter psf_filter_i (.sys_clk, .rst, .msr_wr_en, .msr_rd_en, .msr_addr, .msr_wdata, .msr_rdata,
    .msr_rd_valid, .msr_addr_err, .data_address_profiling_en(prof), .smp_valid, .smp_event_select, .smp_umask,
    .smp_counter_idx, .smp_lin_addr, .smp_first_level_store_hit, .smp_load_uop_cond,
    .precise_event_sampling_count(cnt), .precise_event_sampling_refused(refd), .ocr_valid, .ocr_cfg_sel,
    .ocr_req_type, .ocr_supplier, .ocr_match, .rec_valid, .rec_offset, .rec_data);
  psf_evt_src psf_evt_src_i (.sys_clk, .fire, .fld, .addr, .smp_valid, .smp_event_select, .smp_umask,
    .smp_counter_idx, .smp_lin_addr, .smp_first_level_store_hit, .smp_load_uop_cond);
  task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(logic [31:0] a, psf_word_t d);
    @(negedge sys_clk);
    {msr_wr_en, msr_addr, msr_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    {msr_wr_en, msr_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(logic [31:0] a, psf_word_t e, logic err);
    @(negedge sys_clk);
    {msr_rd_en, msr_addr} = {1'b1, a};
    @(negedge sys_clk);
    msr_rd_en = 1'b0;
    chk("rdata", msr_rdata, e);
    chk("addr_err", msr_addr_err, err);
    if (!err) chk("rd_valid", msr_rd_valid, 1'b1);
  endtask
  task automatic ocr(logic s, logic [15:0] r, logic [14:0] p, logic e);
    @(negedge sys_clk);
    {ocr_valid, ocr_cfg_sel, ocr_req_type, ocr_supplier} = {1'b1, s, r, p};
    @(negedge sys_clk);
    {ocr_valid, ocr_req_type, ocr_supplier} = {1'b0, ~r, ~p};
    chk("ocr_match", ocr_match, e);
  endtask
  task automatic smp(logic [15:0] eu, logic [3:0] c, logic e, logic r);
    @(negedge sys_clk);
    fire <= 1'b1;
    fld <= {1'b0, eu, c, idx, hit};
    @(negedge sys_clk);
    fire <= 1'b0;
    @(negedge sys_clk);
    chk("count", cnt, e);
    chk("refused", refd, r);
  endtask
  task automatic rec(logic [7:0] o, psf_word_t d);
    chk("record", rq.size() > 0 ? rq.pop_front() : 72'hx, {o, d});
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    rd(MSR_FILTER0_ADDR, FILTER_RESET, 1'b0);
    rd(MSR_FILTER1_ADDR, FILTER_RESET, 1'b0);
    wr(MSR_FILTER0_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(MSR_FILTER0_ADDR, 64'h0000_003F_8C5F_9D8B, 1'b0);
    ocr(1'b0, 16'h6274, 15'h7FFF, 1'b0);
    wr(MSR_FILTER1_ADDR, 64'h0000_0000_0001_0001);
    rd(MSR_FILTER0_ADDR, 64'h0000_003F_8C5F_9D8B, 1'b0);
    rd(32'h0000_01A8, 64'h0, 1'b1);
    ocr(1'b1, 16'h0001, 15'h0004, 1'b1);
    ocr(1'b1, 16'h0002, 15'h7FFF, 1'b0);
    $display("test registers done");
    foreach (rb[i]) begin
      wr(MSR_FILTER0_ADDR, 64'h1 << rb[i] | 64'h0002_0000);
      ocr(1'b0, 16'h1 << rb[i], 15'h0002, 1'b1);
      ocr(1'b0, ~(16'h1 << rb[i]), 15'h0002, 1'b0);
    end
    foreach (sb[i]) begin
      wr(MSR_FILTER1_ADDR, 64'h1 << sb[i] | 64'h1);
      ocr(1'b1, 16'h0001, 15'h1 << (sb[i] - 16), 1'b1);
      ocr(1'b1, 16'h0001, ~(15'h1 << (sb[i] - 16)), 1'b0);
    end
    $display("test matcher done");
    rq.delete();
    foreach (tab[i]) begin
      smp(tab[i][15:0], 4'h1, tab[i][16], !tab[i][16]);
      n_ok += tab[i][16];
      repeat (6) @(negedge sys_clk);
    end
    chk("records", rq.size(), n_ok);
    rq.delete();
    smp(16'hD101, 4'h0, 1'b0, 1'b1);
    smp(16'hD101, 4'h8, 1'b1, 1'b0);
    $display("test event pairs done");
    repeat (6) @(negedge sys_clk);
    rq.delete();
    prof = 1'b1;
    foreach (st[i]) begin
      {idx, hit, addr} = {idx + 2'h1, st[i][17], ~addr};
      smp(st[i][15:0], 4'h1, 1'b1, 1'b0);
      if (i == 0) smp(16'hC404, 4'h1, 1'b1, 1'b1);
      repeat (6) @(negedge sys_clk);
      rec(REC_OFS_COUNTER, {62'h0, idx});
      rec(REC_OFS_ADDR, addr);
      rec(REC_OFS_STATUS, {63'h0, st[i][16]});
      rec(REC_OFS_ZERO, 64'h0);
    end
    chk("extra records", rq.size(), 0);
    $display("test records done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd(MSR_FILTER1_ADDR, FILTER_RESET, 1'b0);
    $display("test reset done");
    print_verdict();
  end
endmodule
